// ===== fgr_bar_regs.sv
`timescale 1ns/1ps
`include "fgr_defs.svh"
// Summary of operation
// RQ1: Every control register occupies one 64-bit aligned location.
// RQ2: Only data bits 31..0 are used; bits 63..32 ignored, read zero.
// RQ3: Registers accept both 32-bit and 64-bit host accesses.
// RQ4: Little-endian lanes; byte seven of a location is bits 63..56.
// RQ5: Serial port is eight 8-bit registers on 64-bit steps.
// RQ6: Dual-port memory takes 64-bit or 32-bit aligned accesses.
// RQ7: Dual-port memory reads return zero during any acquisition.
// RQ8: Control-table region has storage for its first 256 locations.
// RQ9: Second base address decodes a 16M window of all resources.
// RQ10: First base address has nothing behind it.
// RQ11: Each register and region decodes at its fixed offset.
// RQ12: Two read-only board information registers ignore writes.
// RQ13: Configuration space reports a family-specific device identifier.
// RQ14: Downloader can program either downloader or operational firmware.
// RQ15: Unmapped offsets read zero and discard writes.
module fgr_bar_regs #(
  parameter logic [15:0] DEVICE_ID = 16'h0ABC, // Arbitrary value.
  parameter logic [31:0] INFO_HIGH = 32'h00000000, // Arbitrary value.
  parameter logic [31:0] INFO_LOW = 32'h00000000, // Arbitrary value.
  parameter int DPM_DEPTH = `FGR_DPM_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Host window access
  input fgr_pkg::fgr_req_t host_req,
  output fgr_pkg::fgr_rsp_t host_rsp,
  // Acquisition state
  input wire logic continuous_acquisition,
  input wire logic single_frame_acquisition,
  // Control bank toward the capture logic
  output logic [`FGR_NREG*32-1:0] ctrl_bank,
  // Firmware downloader
  output logic fw_prog_start,
  output logic fw_image_sel,
  // Configuration space
  output logic [15:0] cfg_device_id
);
  localparam int DAW = $clog2(DPM_DEPTH);
  localparam logic [23:0] REG_OFS [`FGR_NREG] = '{
    `FGR_OFS_CAMERA_CTRL_A, `FGR_OFS_ENCODER_CTRL_A,
    `FGR_OFS_ENCODER_CTRL_B, `FGR_OFS_CAMERA_CTRL_B,
    `FGR_OFS_CAMERA_CTRL_C, `FGR_OFS_CAMERA_CTRL_D,
    `FGR_OFS_ENCODER_CTRL_C, `FGR_OFS_CAMERA_CTRL_E,
    `FGR_OFS_CAMERA_CTRL_F, `FGR_OFS_CAMERA_CTRL_G,
    `FGR_OFS_DMA_CTRL_A, `FGR_OFS_DMA_CTRL_B, `FGR_OFS_DMA_CTRL_C,
    `FGR_OFS_DMA_CTRL_D, `FGR_OFS_DMA_CTRL_E, `FGR_OFS_DMA_CTRL_F,
    `FGR_OFS_DMA_COMMAND_CTRL, `FGR_OFS_DMA_INTERRUPT_INTERVAL,
    `FGR_OFS_ENCODER_CTRL_D, `FGR_OFS_CAMERA_CTRL_H,
    `FGR_OFS_CAMERA_CTRL_I, `FGR_OFS_CAMERA_CTRL_J,
    `FGR_OFS_CAMERA_CTRL_K, `FGR_OFS_CAMERA_CTRL_L,
    `FGR_OFS_CAMERA_CTRL_M, `FGR_OFS_OUTPUT_SOURCE_CTRL,
    `FGR_OFS_CAMERA_CTRL_N, `FGR_OFS_CAMERA_CTRL_O,
    `FGR_OFS_CAMERA_CTRL_P, `FGR_OFS_CAMERA_CTRL_Q,
    `FGR_OFS_CAMERA_CTRL_R, `FGR_OFS_CAMERA_CTRL_S,
    `FGR_OFS_CAMERA_CTRL_T, `FGR_OFS_CAMERA_CTRL_U,
    `FGR_OFS_CAMERA_CTRL_V, `FGR_OFS_CAMERA_CTRL_W,
    `FGR_OFS_DOWNLOAD_CLOCK_CTRL
  };

  // ========================================================================
  // State
  typedef struct packed {
    fgr_pkg::fgr_rsp_t rsp;
    logic [`FGR_NREG-1:0][31:0] ctrl;
    logic [`FGR_UART_DEPTH-1:0][7:0] uart;
    logic [`FGR_CONTROL_TABLE_DEPTH-1:0][31:0] control_table;
    logic [DPM_DEPTH-1:0][63:0] dual_port_memory;
    logic prog_start;
    logic [15:0] dev_id;
    logic miss;
  } fgr_state_t;

  fgr_state_t state_q;
  fgr_state_t state_d;
  fgr_pkg::fgr_region_t region;
  logic [5:0] reg_idx;
  logic lo_sel;
  logic hi_sel;
  logic acq_active;
  logic [63:0] rd_word;

  // ========================================================================
  // Decode and access
  always_comb begin
    state_d = state_q;
    state_d.rsp.valid = 1'b0;
    state_d.prog_start = 1'b0;
    state_d.dev_id = DEVICE_ID;
    region = fgr_pkg::FGR_RG_NONE;
    reg_idx = 6'h00;
    rd_word = 64'h0000000000000000;
    // RQ4: lane selection
    lo_sel = host_req.wide | ~host_req.addr[2];
    hi_sel = host_req.wide | host_req.addr[2];
    acq_active = continuous_acquisition | single_frame_acquisition;
    // RQ10: first window empty
    // RQ9: 16M register window
    if (host_req.bar == `FGR_BAR_REGS) begin
      // RQ11: fixed offsets
      // RQ1: 64-bit aligned locations
      for (int i = 0; i < `FGR_NREG; i++) begin
        if (host_req.addr[23:3] == REG_OFS[i][23:3]) begin
          region = fgr_pkg::FGR_RG_CTRL;
          reg_idx = 6'(i);
        end
      end
      if (host_req.addr[23:3] == `FGR_OFS_BOARD_INFO_HIGH >> 3) begin
        region = fgr_pkg::FGR_RG_INFO;
        reg_idx = 6'h01;
      end else if (host_req.addr[23:3] == `FGR_OFS_BOARD_INFO_LOW >> 3) begin
        region = fgr_pkg::FGR_RG_INFO;
        reg_idx = 6'h00;
      // RQ8: populated table
      end else if (host_req.addr[23:11] == `FGR_OFS_CONTROL_TABLE_REGION >> 11)
      begin
        region = fgr_pkg::FGR_RG_CONTROL_TABLE;
      end else if (host_req.addr[23:3+DAW] ==
                   (`FGR_OFS_DUAL_PORT_MEMORY >> (3 + DAW))) begin
        region = fgr_pkg::FGR_RG_DPM;
      // RQ5: serial registers
      end else if (host_req.addr[23:6] == `FGR_OFS_UART >> 6) begin
        region = fgr_pkg::FGR_RG_UART;
      end
    end
    if (host_req.valid) begin
      if (host_req.write) begin
        // RQ2: low lanes only
        if (region == fgr_pkg::FGR_RG_CTRL && lo_sel) begin
          state_d.ctrl[reg_idx] = host_req.wdata[31:0];
          // RQ14: program request
          if (reg_idx == 6'(`FGR_IDX_DOWNLOAD_CLOCK_CTRL)) begin
            state_d.prog_start = host_req.wdata[`FGR_DL_PROG_START_BIT];
          end
        end else if (region == fgr_pkg::FGR_RG_CONTROL_TABLE && lo_sel) begin
          state_d.control_table[host_req.addr[10:3]] = host_req.wdata[31:0];
        end else if (region == fgr_pkg::FGR_RG_DPM) begin
          // RQ6: half or full word
          if (lo_sel) begin
            state_d.dual_port_memory[host_req.addr[3+:DAW]][31:0] = host_req.wdata[31:0];
          end
          if (hi_sel) begin
            state_d.dual_port_memory[host_req.addr[3+:DAW]][63:32] =
              host_req.wdata[63:32];
          end
        end else if (region == fgr_pkg::FGR_RG_UART && lo_sel) begin
          state_d.uart[host_req.addr[5:3]] = host_req.wdata[7:0];
        end
      end else begin
        // RQ3: either width
        if (region == fgr_pkg::FGR_RG_CTRL) begin
          rd_word = {32'h00000000, state_q.ctrl[reg_idx]};
        end else if (region == fgr_pkg::FGR_RG_INFO) begin
          // RQ12: read-only information
          rd_word = {32'h00000000, reg_idx[0] ? INFO_HIGH : INFO_LOW};
        end else if (region == fgr_pkg::FGR_RG_CONTROL_TABLE) begin
          rd_word = {32'h00000000, state_q.control_table[host_req.addr[10:3]]};
        end else if (region == fgr_pkg::FGR_RG_DPM) begin
          // RQ7: inhibited during acquisition
          rd_word = acq_active ? 64'h0000000000000000 :
                    state_q.dual_port_memory[host_req.addr[3+:DAW]];
        end else if (region == fgr_pkg::FGR_RG_UART) begin
          rd_word = {56'h00000000000000, state_q.uart[host_req.addr[5:3]]};
        end
        state_d.rsp.valid = 1'b1;
        state_d.rsp.data[31:0] = lo_sel ? rd_word[31:0] : 32'h00000000;
        state_d.rsp.data[63:32] = hi_sel ? rd_word[63:32] : 32'h00000000;
      end
    end
    // RQ15: unmapped reads zero
    state_d.miss = host_req.valid & (region == fgr_pkg::FGR_RG_NONE);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ========================================================================
  // Outputs
  assign host_rsp = state_q.rsp;
  assign ctrl_bank = state_q.ctrl;
  assign fw_prog_start = state_q.prog_start;
  assign fw_image_sel =
    state_q.ctrl[`FGR_IDX_DOWNLOAD_CLOCK_CTRL][`FGR_DL_IMAGE_SEL_BIT];
  // RQ13: device identifier
  assign cfg_device_id = state_q.dev_id;

  // ========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // RQ7: dual-port inhibit
  dpm_read_inhibit_a: assert property ( // RQ7
    host_req.valid && !host_req.write && region == fgr_pkg::FGR_RG_DPM &&
    acq_active |=> host_rsp.valid && host_rsp.data == 64'h0)
    else $error("dual-port read during acquisition not zero");
  // RQ3: read answer timing
  read_answer_a: assert property ( // RQ3
    host_req.valid && !host_req.write |=> host_rsp.valid ##1
    (!host_rsp.valid || $past(host_req.valid && !host_req.write)))
    else $error("read answer not one cycle later");
  // RQ10: empty first window
  bar_empty_a: assert property ( // RQ10
    host_req.valid && !host_req.write && host_req.bar != `FGR_BAR_REGS
    |=> host_rsp.data == 64'h0)
    else $error("first window returned data");
  // RQ2: upper lanes of registers
  reg_upper_zero_a: assert property ( // RQ2
    host_req.valid && !host_req.write && region == fgr_pkg::FGR_RG_CTRL
    |=> host_rsp.data[63:32] == 32'h0)
    else $error("register upper half not zero");
  // RQ12: information registers
  info_value_a: assert property ( // RQ12
    host_req.valid && !host_req.write && lo_sel && host_req.bar &&
    host_req.addr == `FGR_OFS_BOARD_INFO_HIGH
    |=> host_rsp.data == {32'h0, INFO_HIGH})
    else $error("information register value wrong");
  // RQ15: unmapped access
  unmapped_zero_a: assert property ( // RQ15
    state_q.miss && host_rsp.valid |-> host_rsp.data == 64'h0)
    else $error("unmapped read not zero");
  // RQ11: register write lands
  reg_write_land_a: assert property ( // RQ11
    host_req.valid && host_req.write && lo_sel && host_req.bar &&
    host_req.addr == `FGR_OFS_DMA_INTERRUPT_INTERVAL
    |=> ctrl_bank[`FGR_IDX_DMA_INTERRUPT_INTERVAL*32 +: 32] ==
    $past(host_req.wdata[31:0]))
    else $error("interval register not written");
  // RQ5: serial register width
  uart_width_a: assert property ( // RQ5
    host_req.valid && !host_req.write && region == fgr_pkg::FGR_RG_UART
    |=> host_rsp.data[63:8] == 56'h0)
    else $error("serial register wider than eight bits");
  // RQ14: program pulse
  prog_pulse_a: assert property ( // RQ14
    fw_prog_start |-> $past(host_req.valid && host_req.write &&
    host_req.bar && lo_sel &&
    host_req.addr == `FGR_OFS_DOWNLOAD_CLOCK_CTRL &&
    host_req.wdata[`FGR_DL_PROG_START_BIT]))
    else $error("program start without a request");
  // RQ8: table write lands
  control_table_write_land_a: assert property ( // RQ8
    host_req.valid && host_req.write && lo_sel &&
    region == fgr_pkg::FGR_RG_CONTROL_TABLE
    |=> state_q.control_table[$past(host_req.addr[10:3])] ==
    $past(host_req.wdata[31:0]))
    else $error("control table write lost");
  // RQ6: upper half write
  dpm_half_write_a: assert property ( // RQ6
    host_req.valid && host_req.write && hi_sel && !lo_sel &&
    region == fgr_pkg::FGR_RG_DPM
    |=> state_q.dual_port_memory[$past(host_req.addr[3+:DAW])][63:32] ==
    $past(host_req.wdata[63:32]))
    else $error("dual-port upper half not written");
  // RQ13: identifier
  device_id_a: assert property ( // RQ13
    $past(!reset) |-> cfg_device_id == DEVICE_ID)
    else $error("device identifier wrong");

  dpm_blocked_c: cover property (
    host_req.valid && !host_req.write && region == fgr_pkg::FGR_RG_DPM &&
    acq_active);
  control_table_write_c: cover property (
    host_req.valid && host_req.write && region == fgr_pkg::FGR_RG_CONTROL_TABLE);
  half_read_c: cover property (
    host_req.valid && !host_req.write && !host_req.wide && host_req.addr[2]);
  prog_c: cover property (fw_prog_start && fw_image_sel);
endmodule

// ===== fgr_defs.svh
`ifndef FGR_DEFS_SVH
`define FGR_DEFS_SVH
// ==========================================================================
// Window layout
`define FGR_WIN_AW 24
`define FGR_NREG 37
`define FGR_DPM_DEPTH 256
`define FGR_CONTROL_TABLE_DEPTH 256
`define FGR_UART_DEPTH 8
`define FGR_BAR_REGS 1'b1
// ==========================================================================
// Control register offsets
`define FGR_OFS_CAMERA_CTRL_A 24'h000000
`define FGR_OFS_ENCODER_CTRL_A 24'h000008
`define FGR_OFS_ENCODER_CTRL_B 24'h000010
`define FGR_OFS_CAMERA_CTRL_B 24'h000018
`define FGR_OFS_CAMERA_CTRL_C 24'h000020
`define FGR_OFS_CAMERA_CTRL_D 24'h000028
`define FGR_OFS_ENCODER_CTRL_C 24'h000030
`define FGR_OFS_CAMERA_CTRL_E 24'h000038
`define FGR_OFS_CAMERA_CTRL_F 24'h000040
`define FGR_OFS_CAMERA_CTRL_G 24'h000048
`define FGR_OFS_DMA_CTRL_A 24'h000050
`define FGR_OFS_DMA_CTRL_B 24'h000058
`define FGR_OFS_DMA_CTRL_C 24'h000060
`define FGR_OFS_DMA_CTRL_D 24'h000068
`define FGR_OFS_DMA_CTRL_E 24'h000070
`define FGR_OFS_DMA_CTRL_F 24'h000078
`define FGR_OFS_DMA_COMMAND_CTRL 24'h000080
`define FGR_OFS_DMA_INTERRUPT_INTERVAL 24'h000088
`define FGR_OFS_ENCODER_CTRL_D 24'h0000F0
`define FGR_OFS_CAMERA_CTRL_H 24'h020000
`define FGR_OFS_CAMERA_CTRL_I 24'h040000
`define FGR_OFS_CAMERA_CTRL_J 24'h060000
`define FGR_OFS_CAMERA_CTRL_K 24'h080000
`define FGR_OFS_CAMERA_CTRL_L 24'h0A0000
`define FGR_OFS_CAMERA_CTRL_M 24'h0C0000
`define FGR_OFS_OUTPUT_SOURCE_CTRL 24'h0E0000
`define FGR_OFS_CAMERA_CTRL_N 24'h100000
`define FGR_OFS_CAMERA_CTRL_O 24'h100008
`define FGR_OFS_CAMERA_CTRL_P 24'h100010
`define FGR_OFS_CAMERA_CTRL_Q 24'h100018
`define FGR_OFS_CAMERA_CTRL_R 24'h100020
`define FGR_OFS_CAMERA_CTRL_S 24'h100028
`define FGR_OFS_CAMERA_CTRL_T 24'h100030
`define FGR_OFS_CAMERA_CTRL_U 24'h100038
`define FGR_OFS_CAMERA_CTRL_V 24'h100040
`define FGR_OFS_CAMERA_CTRL_W 24'h100048
`define FGR_OFS_DOWNLOAD_CLOCK_CTRL 24'h800000
`define FGR_OFS_BOARD_INFO_HIGH 24'h800008
`define FGR_OFS_BOARD_INFO_LOW 24'h800010
// ==========================================================================
// Memory regions
`define FGR_OFS_CONTROL_TABLE_REGION 24'h200000
`define FGR_OFS_DUAL_PORT_MEMORY 24'h500000
`define FGR_OFS_UART 24'h700000
// ==========================================================================
// Indices into the control bank
`define FGR_IDX_DMA_INTERRUPT_INTERVAL 17
`define FGR_IDX_DOWNLOAD_CLOCK_CTRL 36
// ==========================================================================
// Field positions and reset values
`define FGR_DL_PROG_START_BIT 0
`define FGR_DL_IMAGE_SEL_BIT 1
`define FGR_CTRL_RESET 32'h00000000
`endif

// ===== fgr_pkg.sv
package fgr_pkg;
  // Host access into the window; data sits on its natural 64-bit lanes.
  typedef struct packed {
    logic valid;
    logic write;
    logic bar;
    logic wide;
    logic [23:0] addr;
    logic [63:0] wdata;
  } fgr_req_t;
  // Read answer.
  typedef struct packed {
    logic valid;
    logic [63:0] data;
  } fgr_rsp_t;
  typedef enum logic [2:0] {
    FGR_RG_NONE = 3'b000,
    FGR_RG_CTRL = 3'b001,
    FGR_RG_INFO = 3'b010,
    FGR_RG_CONTROL_TABLE = 3'b011,
    FGR_RG_DPM = 3'b100,
    FGR_RG_UART = 3'b101
  } fgr_region_t;
endpackage

// ===== fgr_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Host side of the register window
module fgr_host_model (
  // Clock
  input wire logic sys_clk,
  // Requests toward the window
  output fgr_pkg::fgr_req_t host_req
);
  initial begin
    host_req = '0;
  end
  task automatic access(input logic wr, input logic [1:0] bw,
    input logic [23:0] a, input logic [63:0] d);
    host_req.valid = 1'b1;
    host_req.write = wr;
    host_req.bar = bw[1];
    host_req.wide = bw[0];
    host_req.addr = a;
    host_req.wdata = d;
    @(posedge sys_clk);
    #1;
  endtask
  // Released data lines toggle so that a stale value never looks valid.
  task automatic idle();
    host_req.valid = 1'b0;
    host_req.wdata = ~host_req.wdata;
  endtask
endmodule

// ===== frame_grabber_bar_register_map_tb_top.sv
`timescale 1ns/1ps
`include "fgr_defs.svh"
module frame_grabber_bar_register_map_tb_top;
  localparam logic [15:0] DEV_ID = 16'h1234; // Arbitrary value.
  localparam logic [31:0] INFO_A = 32'hA5C3_0F01; // Arbitrary value.
  localparam logic [31:0] INFO_B = 32'h5A3C_F010; // Arbitrary value.
  localparam logic [1:0] W64 = 2'b11;
  localparam logic [1:0] W32 = 2'b10;
  localparam logic [1:0] NOBAR = 2'b01;
  logic sys_clk;
  logic reset;
  fgr_pkg::fgr_req_t host_req;
  fgr_pkg::fgr_rsp_t host_rsp;
  logic continuous_acquisition;
  logic single_frame_acquisition;
  logic [`FGR_NREG*32-1:0] ctrl_bank;
  logic fw_prog_start;
  logic fw_image_sel;
  logic [15:0] cfg_device_id;
  logic [63:0] exp_q[$];
  logic [63:0] d;
  logic [63:0] e;
  logic [7:0] sv[8];
  int n_mismatch;
  int cmp_count;
  integer seed;

  fgr_host_model host (.sys_clk(sys_clk), .host_req(host_req));
  fgr_bar_regs #(.DEVICE_ID(DEV_ID), .INFO_HIGH(INFO_A), .INFO_LOW(INFO_B))
    uut (.sys_clk(sys_clk), .reset(reset), .host_req(host_req),
    .host_rsp(host_rsp), .continuous_acquisition(continuous_acquisition),
    .single_frame_acquisition(single_frame_acquisition),
    .ctrl_bank(ctrl_bank), .fw_prog_start(fw_prog_start),
    .fw_image_sel(fw_image_sel), .cfg_device_id(cfg_device_id));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] bw, input logic [23:0] a,
    input logic [63:0] v);
    host.access(1'b1, bw, a, v);
  endtask
  task automatic rd(input logic [1:0] bw, input logic [23:0] a,
    input logic [63:0] exp);
    exp_q.push_back(exp);
    host.access(1'b0, bw, a, 64'h0);
    check("answer valid", {63'h0, host_rsp.valid}, 64'h1);
  endtask
  function automatic logic [23:0] ofs(input int i);
    if (i < 18) return 24'(8 * i);
    if (i == 18) return 24'h0000F0;
    if (i < 26) return 24'(32'h20000 * (i - 18));
    if (i < 36) return 24'(32'h100000 + 8 * (i - 26));
    return 24'h800000;
  endfunction

  // ========================================================================
  // Answer watcher
  always @(negedge sys_clk) begin
    if (host_rsp.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unasked answer", 64'h1, 64'h0);
      end else begin
        check("read data", host_rsp.data, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end

  // ========================================================================
  // Main sequence
  initial begin
    seed = 10;
    n_mismatch = 0;
    cmp_count = 0;
    continuous_acquisition = 1'b0;
    single_frame_acquisition = 1'b0;
    reset = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    check("bank reset", {63'h0, ctrl_bank === '0}, 64'h1);
    reset = 1'b0;
    @(posedge sys_clk);
    #1;
    check("device id", {48'h0, cfg_device_id}, {48'h0, DEV_ID});
    for (int i = 0; i < `FGR_NREG; i++) begin
      d = {$random(seed), $random(seed)};
      wr(W64, ofs(i), d);
      check("bank", {32'h0, ctrl_bank[i*32+:32]}, {32'h0, d[31:0]});
      rd(W64, ofs(i), {32'h0, d[31:0]});
    end
    d = {$random(seed), $random(seed)};
    wr(W32, 24'h000088, d);
    rd(W32, 24'h000088, {32'h0, d[31:0]});
    wr(W32, 24'h00008C, ~d);
    rd(W32, 24'h00008C, 64'h0);
    wr(NOBAR, 24'h000088, ~d);
    rd(NOBAR, 24'h000088, 64'h0);
    wr(W64, 24'h000098, ~d);
    rd(W64, 24'h000098, 64'h0);
    rd(W64, 24'h800018, 64'h0);
    rd(W64, 24'h000088, {32'h0, d[31:0]});
    wr(W64, 24'h800008, ~d);
    wr(W64, 24'h800010, ~d);
    rd(W64, 24'h800008, {32'h0, INFO_A});
    rd(W64, 24'h800010, {32'h0, INFO_B});
    for (int i = 0; i < 8; i++) begin
      d = {$random(seed), $random(seed)};
      sv[i] = d[7:0];
      wr(W64, 24'h700000 + 24'(8 * i), d);
    end
    for (int i = 0; i < 8; i++) begin
      rd(W64, 24'h700000 + 24'(8 * i), {56'h0, sv[i]});
    end
    wr(W64, 24'h200000, d);
    wr(W64, 24'h2007F8, ~d);
    wr(W64, 24'h200800, d);
    rd(W64, 24'h200000, {32'h0, d[31:0]});
    rd(W64, 24'h2007F8, {32'h0, ~d[31:0]});
    rd(W64, 24'h200800, 64'h0);
    d = {$random(seed), $random(seed)};
    e = {$random(seed), $random(seed)};
    wr(W64, 24'h500000, d);
    wr(W64, 24'h5007F8, e);
    wr(W32, 24'h5007FC, {d[31:0], ~e[31:0]});
    rd(W64, 24'h500000, d);
    rd(W64, 24'h5007F8, {d[31:0], e[31:0]});
    rd(W32, 24'h5007FC, {d[31:0], 32'h0});
    rd(W32, 24'h5007F8, {32'h0, e[31:0]});
    continuous_acquisition = 1'b1;
    rd(W64, 24'h500000, 64'h0);
    continuous_acquisition = 1'b0;
    single_frame_acquisition = 1'b1;
    rd(W32, 24'h5007F8, 64'h0);
    single_frame_acquisition = 1'b0;
    rd(W64, 24'h500000, d);
    wr(W64, 24'h800000, 64'h3);
    check("prog start", {63'h0, fw_prog_start}, 64'h1);
    check("image sel", {63'h0, fw_image_sel}, 64'h1);
    wr(W64, 24'h800000, 64'h2);
    check("prog start", {63'h0, fw_prog_start}, 64'h0);
    check("image sel", {63'h0, fw_image_sel}, 64'h1);
    wr(W64, 24'h800000, 64'h0);
    check("image sel", {63'h0, fw_image_sel}, 64'h0);
    host.idle();
    reset = 1'b1;
    @(posedge sys_clk);
    #1;
    reset = 1'b0;
    check("bank reset", {63'h0, ctrl_bank === '0}, 64'h1);
    rd(W64, 24'h500000, 64'h0);
    host.idle();
    repeat (3) @(posedge sys_clk);
    check("pending answers", 64'(exp_q.size()), 64'h0);
    end_of_test();
  end
endmodule
